// ==== src/sas_map.svh ====
// Behaviour
// - Sixteen parallel result lines, bit 15 MSB
// - First falling strobe, select low: acquire
// - Second edge select high: reference off after
// - Second edge select low: reference stays on
// - Third edge select high: drive result out
// - Done output low once conversion completes
// - Second falling edge ends acquisition, starts hold
// - Conversion done no sooner than 4.7 us after hold, later while no sample is buffered
// - High reset input clears sequence state
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH

// ==========================================================
// Widths and positions
`define SAS_DATA_W          16
`define SAS_MSB_POS         15
`define SAS_UPPER_LOW_POS   8

// ==========================================================
// Timing
`define SAS_CLK_PERIOD_NS   20
`define SAS_CONV_TIME_NS    4700
`define SAS_ACQ_TIME_NS     2000
`define SAS_CS_PULSE_NS     60
`define SAS_CONV_CYCLES     (`SAS_CONV_TIME_NS / `SAS_CLK_PERIOD_NS)
`define SAS_ACQ_CYCLES      ((`SAS_ACQ_TIME_NS + `SAS_CLK_PERIOD_NS - 1) / `SAS_CLK_PERIOD_NS)
`define SAS_CS_CYCLES       ((`SAS_CS_PULSE_NS + `SAS_CLK_PERIOD_NS - 1) / `SAS_CLK_PERIOD_NS)
`define SAS_SYNC_SLACK      4
`define SAS_FIFO_DEPTH      8

// ==========================================================
// Reset values
`define SAS_DATA_RST        16'h0000

`endif

// ==== src/sas_pkg.sv ====
package sas_pkg;
    typedef enum logic [2:0] {
        SAS_DEV_OFF,
        SAS_DEV_ACQ,
        SAS_DEV_CONV,
        SAS_DEV_DONE,
        SAS_DEV_READ
    } sas_dev_state_e;

    typedef enum logic [3:0] {
        SAS_HOST_IDLE,
        SAS_HOST_WAKE_LO,
        SAS_HOST_WAKE_HI,
        SAS_HOST_ACQ,
        SAS_HOST_CONV_LO,
        SAS_HOST_CONV_HI,
        SAS_HOST_WAIT_EOC,
        SAS_HOST_READ_LO,
        SAS_HOST_READ_HI
    } sas_host_state_e;

    typedef logic [15:0] sas_word_t;
endpackage : sas_pkg

// ==== src/sas_if.sv ====
`timescale 1ns/100ps
`include "sas_map.svh"

interface sas_if;
    logic                      cs_n;
    logic                      rd_conv;
    logic                      reset;
    logic                      eoc_n;
    logic [`SAS_DATA_W-1:0]    data;
    logic                      data_oe;
    logic [`SAS_DATA_W-1:0]    bus_level;

    // Released bus reads low at the host
    assign bus_level = data & {`SAS_DATA_W{data_oe}};

    modport device (
        input  cs_n,
        input  rd_conv,
        input  reset,
        output eoc_n,
        output data,
        output data_oe
    );

    modport host (
        output cs_n,
        output rd_conv,
        output reset,
        input  eoc_n,
        input  bus_level
    );
endinterface : sas_if

// ==== src/sas_device.sv ====
`timescale 1ns/100ps
`include "sas_map.svh"

// ==========================================================
// Sample buffer
module sas_fifo #(
    parameter int WIDTH = `SAS_DATA_W,
    parameter int DEPTH = `SAS_FIFO_DEPTH
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             clear_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic [WIDTH-1:0]      rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("sas_fifo: DEPTH must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    logic             push;
    logic             pop;

    assign wr_ready_out = (wr_ptr_q - rd_ptr_q) != (AW+1)'(DEPTH);
    assign rd_valid_out = wr_ptr_q != rd_ptr_q;
    assign push         = wr_valid_in && wr_ready_out;
    assign pop          = rd_ready_in && rd_valid_out;
    assign rd_data_out  = mem_q[rd_ptr_q[AW-1:0]];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clear_in) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clear_in) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end
endmodule // sas_fifo

// ==========================================================
// Converter end
module sas_device #(
    parameter int CONV_CYCLES = `SAS_CONV_CYCLES,
    parameter int FIFO_DEPTH  = `SAS_FIFO_DEPTH
) (
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    sas_if.device                       link,
    input  wire logic [`SAS_DATA_W-1:0] sample_data_in,
    input  wire logic                   sample_valid_in,
    output logic                        sample_ready_out,
    output logic                        powered_out,
    output logic                        ref_on_out,
    output logic                        converting_out
);
    initial begin
        if (CONV_CYCLES < 2 || CONV_CYCLES > 4095) begin
            $error("sas_device: CONV_CYCLES out of range");
        end
    end

    // ======================================================
    // Pin synchronisers, change taken once stages two and three agree
    logic [2:0] cs_sync_q;
    logic [2:0] rc_sync_q;
    logic [2:0] rst_sync_q;
    logic       cs_n_q;
    logic       rc_q;
    logic       dev_reset_q;
    logic       cs_fall;
    logic       cs_rise;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cs_sync_q  <= 3'b111;
            rc_sync_q  <= 3'b000;
            rst_sync_q <= 3'b000;
        end else begin
            cs_sync_q  <= {cs_sync_q[1:0], link.cs_n};
            rc_sync_q  <= {rc_sync_q[1:0], link.rd_conv};
            rst_sync_q <= {rst_sync_q[1:0], link.reset};
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cs_n_q      <= 1'b1;
            rc_q        <= 1'b0;
            dev_reset_q <= 1'b0;
        end else begin
            if (cs_sync_q[1] == cs_sync_q[2]) begin
                cs_n_q <= cs_sync_q[2];
            end
            if (rc_sync_q[1] == rc_sync_q[2]) begin
                rc_q <= rc_sync_q[2];
            end
            if (rst_sync_q[1] == rst_sync_q[2]) begin
                dev_reset_q <= rst_sync_q[2];
            end
        end
    end

    // Select sampled with the strobe that caused the edge
    logic rc_at_edge;
    assign rc_at_edge = (rc_sync_q[1] == rc_sync_q[2]) ? rc_sync_q[2] : rc_q;
    assign cs_fall = cs_n_q && (cs_sync_q[1] == cs_sync_q[2]) && !cs_sync_q[2];
    assign cs_rise = !cs_n_q && (cs_sync_q[1] == cs_sync_q[2]) && cs_sync_q[2];

    // ======================================================
    // Sample buffer in front of the converter
    logic [`SAS_DATA_W-1:0] fifo_data;
    logic                   fifo_valid;
    logic                   fifo_pop;

    sas_fifo #(
        .WIDTH (`SAS_DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .clear_in     (dev_reset_q),
        .wr_data_in   (sample_data_in),
        .wr_valid_in  (sample_valid_in),
        .wr_ready_out (sample_ready_out),
        .rd_data_out  (fifo_data),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (fifo_pop)
    );

    // ======================================================
    // Sequence
    sas_pkg::sas_dev_state_e state_q;
    sas_pkg::sas_dev_state_e state_d;
    logic [11:0]             conv_cnt_q;
    logic                    conv_end;
    logic                    shutdown_q;

    assign conv_end = (state_q == sas_pkg::SAS_DEV_CONV)
                   && (conv_cnt_q >= 12'(CONV_CYCLES - 1)) && fifo_valid;
    assign fifo_pop = conv_end;

    always_comb begin
        state_d = state_q;
        case (state_q)
            sas_pkg::SAS_DEV_OFF: begin
                if (cs_fall && !rc_at_edge) begin
                    state_d = sas_pkg::SAS_DEV_ACQ;
                end
            end
            sas_pkg::SAS_DEV_ACQ: begin
                if (cs_fall) begin
                    state_d = sas_pkg::SAS_DEV_CONV;
                end
            end
            sas_pkg::SAS_DEV_CONV: begin
                if (conv_end) begin
                    state_d = sas_pkg::SAS_DEV_DONE;
                end
            end
            sas_pkg::SAS_DEV_DONE: begin
                if (cs_fall && rc_at_edge) begin
                    state_d = sas_pkg::SAS_DEV_READ;
                end
            end
            sas_pkg::SAS_DEV_READ: begin
                if (cs_rise) begin
                    state_d = sas_pkg::SAS_DEV_OFF;
                end
            end
            default: begin
                state_d = sas_pkg::SAS_DEV_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || dev_reset_q) begin
            state_q <= sas_pkg::SAS_DEV_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || dev_reset_q) begin
            conv_cnt_q <= 12'h0000;
        end else if (state_q != sas_pkg::SAS_DEV_CONV) begin
            conv_cnt_q <= 12'h0000;
        end else if (conv_cnt_q != 12'hfff) begin
            conv_cnt_q <= conv_cnt_q + 12'h0001;
        end
    end

    // Power choice taken at the hold edge
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || dev_reset_q) begin
            shutdown_q <= 1'b1;
        end else if (state_q == sas_pkg::SAS_DEV_ACQ && cs_fall) begin
            shutdown_q <= rc_at_edge;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || dev_reset_q) begin
            ref_on_out <= 1'b0;
        end else if (state_d == sas_pkg::SAS_DEV_ACQ || state_d == sas_pkg::SAS_DEV_CONV) begin
            ref_on_out <= 1'b1;
        end else if (conv_end) begin
            ref_on_out <= !shutdown_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || dev_reset_q) begin
            powered_out    <= 1'b0;
            converting_out <= 1'b0;
        end else begin
            powered_out    <= state_d != sas_pkg::SAS_DEV_OFF;
            converting_out <= state_d == sas_pkg::SAS_DEV_CONV;
        end
    end

    // ======================================================
    // Result and pins
    logic [`SAS_DATA_W-1:0] result_q;
    logic                   eoc_n_q;
    logic                   oe_q;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || dev_reset_q) begin
            result_q <= `SAS_DATA_RST;
        end else if (conv_end) begin
            result_q <= fifo_data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || dev_reset_q) begin
            eoc_n_q <= 1'b1;
        end else if (conv_end) begin
            eoc_n_q <= 1'b0;
        end else if (state_q == sas_pkg::SAS_DEV_READ && cs_rise) begin
            eoc_n_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || dev_reset_q) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= state_d == sas_pkg::SAS_DEV_READ;
        end
    end

    assign link.eoc_n   = eoc_n_q;
    assign link.data    = result_q;
    assign link.data_oe = oe_q;
endmodule // sas_device

// ==== src/sas_host.sv ====
`timescale 1ns/100ps
`include "sas_map.svh"

module sas_host #(
    parameter int ACQ_CYCLES = `SAS_ACQ_CYCLES,
    parameter int CS_CYCLES  = `SAS_CS_CYCLES + `SAS_SYNC_SLACK
) (
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    sas_if.host                         link,
    input  wire logic                   start_in,
    input  wire logic                   shutdown_in,
    input  wire logic                   dev_reset_in,
    output logic                        busy_out,
    output logic [`SAS_DATA_W-1:0]      result_out,
    output logic                        result_valid_out
);
    initial begin
        if (ACQ_CYCLES < 1 || ACQ_CYCLES > 4095 || CS_CYCLES < 4 || CS_CYCLES > 4095) begin
            $error("sas_host: cycle counts out of range");
        end
    end

    // ======================================================
    // Pin synchronisers
    logic [2:0]             eoc_sync_q;
    logic                   eoc_n_q;
    logic [`SAS_DATA_W-1:0] d_s1_q;
    logic [`SAS_DATA_W-1:0] d_s2_q;
    logic [`SAS_DATA_W-1:0] d_s3_q;
    logic [`SAS_DATA_W-1:0] d_q;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            eoc_sync_q <= 3'b111;
            d_s1_q     <= `SAS_DATA_RST;
            d_s2_q     <= `SAS_DATA_RST;
            d_s3_q     <= `SAS_DATA_RST;
        end else begin
            eoc_sync_q <= {eoc_sync_q[1:0], link.eoc_n};
            d_s1_q     <= link.bus_level;
            d_s2_q     <= d_s1_q;
            d_s3_q     <= d_s2_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            eoc_n_q <= 1'b1;
            d_q     <= `SAS_DATA_RST;
        end else begin
            if (eoc_sync_q[1] == eoc_sync_q[2]) begin
                eoc_n_q <= eoc_sync_q[2];
            end
            for (int i = 0; i < `SAS_DATA_W; i++) begin
                if (d_s2_q[i] == d_s3_q[i]) begin
                    d_q[i] <= d_s3_q[i];
                end
            end
        end
    end

    // ======================================================
    // Strobe sequence
    sas_pkg::sas_host_state_e state_q;
    logic [11:0]              cnt_q;
    logic                     cnt_done;
    logic                     shutdown_q;

    assign cnt_done = cnt_q == 12'h0000;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || dev_reset_in) begin
            state_q    <= sas_pkg::SAS_HOST_IDLE;
            cnt_q      <= 12'h0000;
            shutdown_q <= 1'b0;
        end else begin
            if (!cnt_done) begin
                cnt_q <= cnt_q - 12'h0001;
            end
            case (state_q)
                sas_pkg::SAS_HOST_IDLE: begin
                    if (start_in) begin
                        shutdown_q <= shutdown_in;
                        cnt_q      <= 12'(CS_CYCLES - 1);
                        state_q    <= sas_pkg::SAS_HOST_WAKE_LO;
                    end
                end
                sas_pkg::SAS_HOST_WAKE_LO: begin
                    if (cnt_done) begin
                        cnt_q   <= 12'(CS_CYCLES - 1);
                        state_q <= sas_pkg::SAS_HOST_WAKE_HI;
                    end
                end
                sas_pkg::SAS_HOST_WAKE_HI: begin
                    if (cnt_done) begin
                        cnt_q   <= 12'(ACQ_CYCLES - 1);
                        state_q <= sas_pkg::SAS_HOST_ACQ;
                    end
                end
                sas_pkg::SAS_HOST_ACQ: begin
                    if (cnt_done) begin
                        cnt_q   <= 12'(CS_CYCLES - 1);
                        state_q <= sas_pkg::SAS_HOST_CONV_LO;
                    end
                end
                sas_pkg::SAS_HOST_CONV_LO: begin
                    if (cnt_done) begin
                        cnt_q   <= 12'(CS_CYCLES - 1);
                        state_q <= sas_pkg::SAS_HOST_CONV_HI;
                    end
                end
                sas_pkg::SAS_HOST_CONV_HI: begin
                    if (cnt_done) begin
                        state_q <= sas_pkg::SAS_HOST_WAIT_EOC;
                    end
                end
                sas_pkg::SAS_HOST_WAIT_EOC: begin
                    if (!eoc_n_q) begin
                        cnt_q   <= 12'(CS_CYCLES + `SAS_SYNC_SLACK - 1);
                        state_q <= sas_pkg::SAS_HOST_READ_LO;
                    end
                end
                sas_pkg::SAS_HOST_READ_LO: begin
                    if (cnt_done) begin
                        cnt_q   <= 12'(CS_CYCLES - 1);
                        state_q <= sas_pkg::SAS_HOST_READ_HI;
                    end
                end
                sas_pkg::SAS_HOST_READ_HI: begin
                    if (cnt_done) begin
                        state_q <= sas_pkg::SAS_HOST_IDLE;
                    end
                end
                default: begin
                    state_q <= sas_pkg::SAS_HOST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || dev_reset_in) begin
            result_out       <= `SAS_DATA_RST;
            result_valid_out <= 1'b0;
        end else begin
            result_valid_out <= 1'b0;
            if (state_q == sas_pkg::SAS_HOST_READ_LO && cnt_done) begin
                result_out       <= d_q;
                result_valid_out <= 1'b1;
            end
        end
    end

    // ======================================================
    // Pin drive
    logic cs_n_q;
    logic rc_q;
    logic reset_q;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cs_n_q  <= 1'b1;
            rc_q    <= 1'b0;
            reset_q <= 1'b1;
        end else begin
            reset_q <= dev_reset_in;
            cs_n_q  <= !(state_q == sas_pkg::SAS_HOST_WAKE_LO
                      || state_q == sas_pkg::SAS_HOST_CONV_LO
                      || state_q == sas_pkg::SAS_HOST_READ_LO);
            if (state_q == sas_pkg::SAS_HOST_IDLE || state_q == sas_pkg::SAS_HOST_WAKE_LO) begin
                rc_q <= 1'b0;
            end else if (state_q == sas_pkg::SAS_HOST_ACQ
                      || state_q == sas_pkg::SAS_HOST_CONV_LO) begin
                rc_q <= shutdown_q;
            end else if (state_q == sas_pkg::SAS_HOST_WAIT_EOC
                      || state_q == sas_pkg::SAS_HOST_READ_LO) begin
                rc_q <= 1'b1;
            end
        end
    end

    assign busy_out     = state_q != sas_pkg::SAS_HOST_IDLE;
    assign link.cs_n    = cs_n_q;
    assign link.rd_conv = rc_q;
    assign link.reset   = reset_q;
endmodule // sas_host

// ==== dv/sas_link_checker.sv ====
`timescale 1ns/100ps
`include "sas_map.svh"

// ==========================================================
// Link protocol checks
module sas_link_checker #(
    parameter int CONV_CYCLES = `SAS_CONV_CYCLES
) (
    input wire logic                   clk_in,
    input wire logic                   rst_n_in,
    input wire logic                   cs_n,
    input wire logic                   rd_conv,
    input wire logic                   reset,
    input wire logic                   eoc_n,
    input wire logic [`SAS_DATA_W-1:0] data,
    input wire logic                   data_oe,
    input wire logic [`SAS_DATA_W-1:0] bus_level
);
    localparam int CONV_LIMIT = CONV_CYCLES + 8;
    logic       cs_q;
    logic       fall;
    logic [2:0] phase_q;
    logic [9:0] wait_q;

    assign fall = cs_q && !cs_n;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    always_ff @(posedge clk_in) begin
        cs_q <= cs_n;
    end

    // Phase: 1 acquire, 2 convert, 3 done, 4 reading
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || reset) begin
            phase_q <= 3'h0;
        end else if (phase_q == 3'h0 && fall && !rd_conv) begin
            phase_q <= 3'h1;
        end else if (phase_q == 3'h1 && fall) begin
            phase_q <= 3'h2;
        end else if (phase_q == 3'h2 && !eoc_n) begin
            phase_q <= 3'h3;
        end else if (phase_q == 3'h3 && data_oe) begin
            phase_q <= 3'h4;
        end else if (phase_q == 3'h4 && !data_oe) begin
            phase_q <= 3'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        wait_q <= (phase_q == 3'h2) ? wait_q + 10'h001 : 10'h000;
    end

    a_eoc_waits: assert property (phase_q == 3'h1 |-> eoc_n)
        else $error("done low during acquisition");
    a_conv_floor: assert property (
        $fell(eoc_n) |-> phase_q == 3'h2 && wait_q >= CONV_CYCLES)
        else $error("conversion ended early");
    a_conv_bound: assert property (phase_q == 3'h2 |-> wait_q <= CONV_LIMIT)
        else $error("conversion too slow");
    a_eoc_stands: assert property (phase_q == 3'h3 && cs_n && !reset |=> !eoc_n)
        else $error("done released before read");
    a_oe_cause: assert property (
        $rose(data_oe) |-> phase_q == 3'h3 && !cs_n && rd_conv)
        else $error("bus driven without read");
    a_oe_release: assert property ($rose(cs_n) |-> ##[1:6] !data_oe)
        else $error("bus not released");
    a_data_stands: assert property (data_oe && $past(data_oe) |-> $stable(data))
        else $error("result changed while driven");
    a_reset_clears: assert property (
        $rose(reset) |-> ##[1:8] (eoc_n && !data_oe && phase_q == 3'h0))
        else $error("reset did not clear sequence");

    c_done: cover property ($fell(eoc_n));
    c_read: cover property ($rose(data_oe));
    c_reset: cover property ($rose(reset));
endmodule // sas_link_checker

// ==== dv/sar_adc_parallel_edge_sequencer_test.sv ====
`timescale 1ns/100ps
`include "sas_map.svh"

module sar_adc_parallel_edge_sequencer_test;
    logic                   clk_in = 1'b0;
    logic                   rst_n_in = 1'b0;
    logic                   start_in = 1'b0;
    logic                   shutdown_in = 1'b0;
    logic                   dev_reset_in = 1'b0;
    logic [`SAS_DATA_W-1:0] sample_data_in = 16'h0000;
    logic [`SAS_DATA_W-1:0] side_sample = 16'h8100;
    logic                   sample_valid_in = 1'b0;
    logic                   sample_ready_out;
    logic                   powered_out;
    logic                   ref_on_out;
    logic                   converting_out;
    logic                   busy_out;
    logic [`SAS_DATA_W-1:0] result_out;
    logic                   result_valid_out;
    logic                   powered_b;
    logic                   ref_on_b;
    int                     failures = 0;
    int                     total_checks = 0;
    int                     cycles = 0;
    // Bit 16 is the shutdown choice, low bits the sample
    logic [16:0]            rows [8] = '{17'h0_8000, 17'h1_0001, 17'h0_ffff, 17'h1_0100,
                                         17'h0_1234, 17'h1_8421, 17'h0_7ffe, 17'h1_0000};

    sas_if link ();
    sas_if side_link ();

    always #10 clk_in = ~clk_in;

    sas_device #(.CONV_CYCLES(10)) sas_device_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
        .sample_data_in(sample_data_in), .sample_valid_in(sample_valid_in),
        .sample_ready_out(sample_ready_out), .powered_out(powered_out),
        .ref_on_out(ref_on_out), .converting_out(converting_out));

    sas_host #(.ACQ_CYCLES(4)) sas_host_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .link(link), .start_in(start_in),
        .shutdown_in(shutdown_in), .dev_reset_in(dev_reset_in), .busy_out(busy_out),
        .result_out(result_out), .result_valid_out(result_valid_out));

    // Second device, strobed directly by the bench
    sas_device #(.CONV_CYCLES(10)) sas_device_inst_b (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .link(side_link),
        .sample_data_in(side_sample), .sample_valid_in(1'b1), .sample_ready_out(),
        .powered_out(powered_b), .ref_on_out(ref_on_b), .converting_out());

    sas_link_checker #(.CONV_CYCLES(10)) sas_link_checker_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n(link.cs_n), .rd_conv(link.rd_conv),
        .reset(link.reset), .eoc_n(link.eoc_n), .data(link.data), .data_oe(link.data_oe),
        .bus_level(link.bus_level));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic strobe(input logic rc);
        side_link.rd_conv = rc;
        side_link.cs_n = 1'b0;
        tick(7);
        side_link.cs_n = 1'b1;
        tick(7);
    endtask

    task automatic final_report;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            final_report();
        end
    end

    task automatic run_one(input logic shd, input logic [15:0] exp);
        int k;
        shutdown_in = shd;
        start_in = 1'b1;
        tick(1);
        start_in = 1'b0;
        for (k = 0; k < 300 && link.eoc_n !== 1'b0; k++) tick(1);
        check({15'h0000, link.eoc_n}, 16'h0000);
        check({14'h0000, powered_out, ref_on_out}, {14'h0000, 1'b1, !shd});
        for (k = 0; k < 300 && result_valid_out !== 1'b1; k++) tick(1);
        check({15'h0000, result_valid_out}, 16'h0001);
        check(result_out, exp);
        for (k = 0; k < 300 && busy_out !== 1'b0; k++) tick(1);
        check({15'h0000, busy_out}, 16'h0000);
    endtask

    initial begin
        int k;
        side_link.cs_n = 1'b1;
        side_link.rd_conv = 1'b0;
        side_link.reset = 1'b0;
        tick(6);
        rst_n_in = 1'b1;
        tick(10);
        // ==========================================================
        // Bench-driven strobes on the second device
        strobe(1'b1);
        check({15'h0000, powered_b}, 16'h0000);
        strobe(1'b0);
        check({15'h0000, powered_b}, 16'h0001);
        strobe(1'b0);
        for (k = 0; k < 100 && side_link.eoc_n !== 1'b0; k++) tick(1);
        check({15'h0000, side_link.eoc_n}, 16'h0000);
        check({15'h0000, ref_on_b}, 16'h0001);
        strobe(1'b0);
        check({15'h0000, side_link.data_oe}, 16'h0000);
        side_link.rd_conv = 1'b1;
        side_link.cs_n = 1'b0;
        tick(7);
        check(side_link.bus_level, 16'h8100);
        side_link.cs_n = 1'b1;
        tick(7);
        check({15'h0000, side_link.data_oe}, 16'h0000);
        strobe(1'b0);
        strobe(1'b1);
        for (k = 0; k < 100 && side_link.eoc_n !== 1'b0; k++) tick(1);
        check({15'h0000, side_link.eoc_n}, 16'h0000);
        check({15'h0000, ref_on_b}, 16'h0000);
        // ==========================================================
        // Fill the buffer until it refuses, then drain it
        sample_valid_in = 1'b1;
        for (int i = 0; i < 8; i++) begin
            sample_data_in = rows[i][15:0];
            tick(1);
        end
        sample_valid_in = 1'b0;
        check({15'h0000, sample_ready_out}, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            run_one(rows[i][16], rows[i][15:0]);
        end
        check({15'h0000, sample_ready_out}, 16'h0001);
        // ==========================================================
        // Device reset in mid-conversion
        sample_valid_in = 1'b1;
        sample_data_in = 16'h5a5a;
        tick(1);
        sample_valid_in = 1'b0;
        start_in = 1'b1;
        tick(1);
        start_in = 1'b0;
        for (k = 0; k < 300 && converting_out !== 1'b1; k++) tick(1);
        check({15'h0000, converting_out}, 16'h0001);
        dev_reset_in = 1'b1;
        tick(4);
        dev_reset_in = 1'b0;
        tick(6);
        check({14'h0000, converting_out, powered_out}, 16'h0000);
        check({15'h0000, link.eoc_n}, 16'h0001);
        sample_valid_in = 1'b1;
        sample_data_in = 16'hc3c3;
        tick(1);
        sample_valid_in = 1'b0;
        run_one(1'b0, 16'hc3c3);
        final_report();
    end
endmodule // sar_adc_parallel_edge_sequencer_test
